// *** verilog/pmx_pin_output_source_mux.sv ***
// output source control for general-purpose pin 2, with its register bus slave
//
// The AXI4-Lite slave port was decided locally.
`include "pmx_defines.svh"

module pmx_pin_output_source_mux (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output pmx_pkg::pmx_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output pmx_pkg::pmx_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] rxRemoteLevel,
  input wire logic [3:0] rxLock,
  input wire logic [3:0] rxPass,
  input wire logic [3:0] rxFrameValid,
  input wire logic [3:0] rxLineValid,
  input wire logic txFrameValid,
  input wire logic txLineValid,
  input wire logic txSynced,
  input wire logic txIrq,
  input wire logic frameSyncPulse,
  input wire logic pin2PadIn,
  output logic pin2PadOut,
  output logic pin2PadOe_b
);
  import pmx_pkg::*;

  localparam logic [7:0] CtrlAddr = 8'(`PMX_CTRL_INDEX * 4);
  localparam logic [7:0] PortsAddr = 8'(`PMX_PORTS_INDEX * 4);
  localparam logic [7:0] StatusAddr = 8'(`PMX_STATUS_INDEX * 4);

  // registers
  logic [7:0] pin2OutputControl_reg;
  logic [7:0] pin2OutputControl_next;
  logic [7:0] portMask_reg;
  logic [7:0] portMask_next;

  // write channel state
  logic awHeld_reg;
  logic [7:0] awAddrHeld_reg;
  logic wHeld_reg;
  logic [7:0] wDataHeld_reg;
  logic wLaneHeld_reg;
  logic bValid_reg;
  pmx_resp_t bResp_reg;

  // read channel state
  logic rValid_reg;
  logic [31:0] rData_reg;
  pmx_resp_t rResp_reg;

  // pin state
  logic pinLevel_reg;
  logic pinOe_b_reg;

  // control fields
  wire [2:0] pin2SignalSelect = pin2OutputControl_reg[`PMX_SEL_MSB:`PMX_SEL_LSB];
  wire [2:0] pin2SourceGroup = pin2OutputControl_reg[`PMX_SRC_MSB:`PMX_SRC_LSB];
  wire pin2LocalLevel = pin2OutputControl_reg[`PMX_VAL_BIT];
  wire pin2DriveEnable = pin2OutputControl_reg[`PMX_EN_BIT];
  wire [3:0] rxEnableMask = portMask_reg[`PMX_ENMASK_MSB:`PMX_ENMASK_LSB];
  wire [3:0] txPassMask = portMask_reg[`PMX_TXMASK_MSB:`PMX_TXMASK_LSB];

  // source group decode
  wire pmx_src_t srcCode = pmx_src_t'(pin2SourceGroup);
  wire srcIsRx = (pin2SourceGroup[2] == 1'b0);
  wire srcIsDevice = (srcCode == SRC_DEVICE);
  wire srcIsTx = (srcCode == SRC_TX0);

  // receive port selection, one selector per port
  wire [3:0] rxPick;
  pmx_rx_if rxPort [4] ();

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_rx
      assign rxPort[gi].remoteLevel = rxRemoteLevel[gi*4 +: 4];
      assign rxPort[gi].lock = rxLock[gi];
      assign rxPort[gi].pass = rxPass[gi];
      assign rxPort[gi].frameValid = rxFrameValid[gi];
      assign rxPort[gi].lineValid = rxLineValid[gi];
      assign rxPort[gi].sel = pin2SignalSelect;
      assign rxPick[gi] = rxPort[gi].pick;
      pmx_rx_port_sel u_sel (
        .port(rxPort[gi])
      );
    end
  endgenerate

  wire rxLevel = rxPick[pin2SourceGroup[1:0]];

  // device status; an empty enable mask gives low for the AND terms too
  wire anyRxEnabled = |rxEnableMask;
  wire lockOrEnabled = |(rxLock & rxEnableMask);
  wire lockAndEnabled = anyRxEnabled & (&(rxLock | ~rxEnableMask));
  wire passAndEnabled = anyRxEnabled & (&(rxPass | ~rxEnableMask));

  wire pmx_devsel_t devCode = pmx_devsel_t'(pin2SignalSelect);
  wire devLocal = (devCode == DEVSEL_LOCAL) & pin2LocalLevel;
  wire devLockOr = (devCode == DEVSEL_LOCK_OR) & lockOrEnabled;
  wire devLockAnd = (devCode == DEVSEL_LOCK_AND) & lockAndEnabled;
  wire devPassAnd = (devCode == DEVSEL_PASS_AND) & passAndEnabled;
  wire devFsync = (devCode == DEVSEL_FSYNC) & frameSyncPulse;
  // codes 101-111 match no term and fall to low
  wire devLevel = devLocal | devLockOr | devLockAnd | devPassAnd | devFsync;

  // transmit port status
  wire anyTxPortSelected = |txPassMask;
  wire txPassAnd = anyTxPortSelected & (&(rxPass | ~txPassMask));
  wire txPassOr = |(rxPass & txPassMask);

  wire pmx_txsel_t txCode = pmx_txsel_t'(pin2SignalSelect);
  wire txAndTerm = (txCode == TXSEL_PASS_AND) & txPassAnd;
  wire txOrTerm = (txCode == TXSEL_PASS_OR) & txPassOr;
  wire txFrameTerm = (txCode == TXSEL_FRAME) & txFrameValid;
  wire txLineTerm = (txCode == TXSEL_LINE) & txLineValid;
  wire txSyncTerm = (txCode == TXSEL_SYNCED) & txSynced;
  wire txIrqTerm = (txCode == TXSEL_IRQ) & txIrq;
  // codes 110 and 111 match no term and fall to low
  wire txLevel = txAndTerm | txOrTerm | txFrameTerm | txLineTerm | txSyncTerm | txIrqTerm;

  // final selection; reserved groups drive low
  wire groupLevel = srcIsRx ? rxLevel : srcIsDevice ? devLevel : srcIsTx ? txLevel : 1'b0;
  // a disabled pin parks its data low as well, so re-enabling never glitches an old level
  wire pinLevel_next = pin2DriveEnable & groupLevel;
  wire pinOe_b_next = ~pin2DriveEnable;

  // write address and data may arrive in either order
  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake = s_axi_wvalid & s_axi_wready;
  wire writeCommit = awHeld_reg & wHeld_reg;
  wire writeCtrl = writeCommit & (awAddrHeld_reg[7:2] == CtrlAddr[7:2]);
  wire writePorts = writeCommit & (awAddrHeld_reg[7:2] == PortsAddr[7:2]);
  wire writeStatus = writeCommit & (awAddrHeld_reg[7:2] == StatusAddr[7:2]);
  wire writeMapped = writeCtrl | writePorts | writeStatus;
  wire bDone = s_axi_bvalid & s_axi_bready;

  assign s_axi_awready = ~awHeld_reg & ~bValid_reg;
  assign s_axi_wready = ~wHeld_reg & ~bValid_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;

  // only byte lane 0 holds register bits; upper lanes are ignored
  assign pin2OutputControl_next = (writeCtrl & wLaneHeld_reg) ? wDataHeld_reg : pin2OutputControl_reg;
  assign portMask_next = (writePorts & wLaneHeld_reg) ? wDataHeld_reg : portMask_reg;

  // status read shows the pin as the block drives and sees it
  wire [7:0] statusWord = {
    2'h0,
    pin2PadIn,
    pinOe_b_reg,
    pinLevel_reg,
    groupLevel,
    srcIsTx,
    srcIsDevice
  };

  // read decode
  wire arTake = s_axi_arvalid & s_axi_arready;
  wire readCtrl = (s_axi_araddr[7:2] == CtrlAddr[7:2]);
  wire readPorts = (s_axi_araddr[7:2] == PortsAddr[7:2]);
  wire readStatus = (s_axi_araddr[7:2] == StatusAddr[7:2]);
  wire readMapped = readCtrl | readPorts | readStatus;
  wire [7:0] readByte = readCtrl ? pin2OutputControl_reg :
    readPorts ? portMask_reg :
    readStatus ? statusWord : 8'h00;
  wire rDone = s_axi_rvalid & s_axi_rready;

  assign s_axi_arready = ~rValid_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;

  assign pin2PadOut = pinLevel_reg;
  assign pin2PadOe_b = pinOe_b_reg;

  // control registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pin2OutputControl_reg <= `PMX_CTRL_RESET;
      portMask_reg <= `PMX_PORTS_RESET;
    end else begin
      pin2OutputControl_reg <= pin2OutputControl_next;
      portMask_reg <= portMask_next;
    end
  end

  // write address holding
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      awHeld_reg <= 1'b0;
      awAddrHeld_reg <= 8'h00;
    end else if (awTake) begin
      awHeld_reg <= 1'b1;
      awAddrHeld_reg <= s_axi_awaddr;
    end else if (writeCommit) begin
      awHeld_reg <= 1'b0;
    end
  end

  // write data holding
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wHeld_reg <= 1'b0;
      wDataHeld_reg <= 8'h00;
      wLaneHeld_reg <= 1'b0;
    end else if (wTake) begin
      wHeld_reg <= 1'b1;
      wDataHeld_reg <= s_axi_wdata[7:0];
      wLaneHeld_reg <= s_axi_wstrb[0];
    end else if (writeCommit) begin
      wHeld_reg <= 1'b0;
    end
  end

  // write response; the status word is read-only and answers okay with no effect
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bValid_reg <= 1'b0;
      bResp_reg <= `PMX_RESP_OKAY;
    end else if (writeCommit) begin
      bValid_reg <= 1'b1;
      bResp_reg <= writeMapped ? `PMX_RESP_OKAY : `PMX_RESP_SLVERR;
    end else if (bDone) begin
      bValid_reg <= 1'b0;
    end
  end

  // read answer
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rValid_reg <= 1'b0;
      rData_reg <= 32'h0000_0000;
      rResp_reg <= `PMX_RESP_OKAY;
    end else if (arTake) begin
      rValid_reg <= 1'b1;
      rData_reg <= {24'h00_0000, readByte};
      rResp_reg <= readMapped ? `PMX_RESP_OKAY : `PMX_RESP_SLVERR;
    end else if (rDone) begin
      rValid_reg <= 1'b0;
    end
  end

  // pin drive, one cycle behind the register and status inputs
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pinLevel_reg <= 1'b0;
      pinOe_b_reg <= 1'b1;
    end else begin
      pinLevel_reg <= pinLevel_next;
      pinOe_b_reg <= pinOe_b_next;
    end
  end

endmodule : pmx_pin_output_source_mux

// *** include/pmx_defines.svh ***
// register offsets, field positions and reset values of the pin output source mux
`ifndef PMX_DEFINES_SVH
`define PMX_DEFINES_SVH

// register indices; byte address is four times the index
`define PMX_CTRL_INDEX 8'h12
`define PMX_PORTS_INDEX 8'h20
`define PMX_STATUS_INDEX 8'h21

// control register fields
`define PMX_SEL_MSB 7
`define PMX_SEL_LSB 5
`define PMX_SRC_MSB 4
`define PMX_SRC_LSB 2
`define PMX_VAL_BIT 1
`define PMX_EN_BIT 0
`define PMX_CTRL_RESET 8'h00

// port mask register fields
`define PMX_ENMASK_MSB 3
`define PMX_ENMASK_LSB 0
`define PMX_TXMASK_MSB 7
`define PMX_TXMASK_LSB 4
`define PMX_PORTS_RESET 8'h00

// bus answers
`define PMX_RESP_OKAY 2'h0
`define PMX_RESP_SLVERR 2'h2

`endif

// *** include/pmx_pkg.sv ***
// types of the pin output source mux
package pmx_pkg;

  typedef logic [1:0] pmx_resp_t;

  typedef enum logic [2:0] {
    SRC_RX0 = 3'b000,
    SRC_RX1 = 3'b001,
    SRC_RX2 = 3'b010,
    SRC_RX3 = 3'b011,
    SRC_DEVICE = 3'b100,
    SRC_RSVD5 = 3'b101,
    SRC_TX0 = 3'b110,
    SRC_RSVD7 = 3'b111
  } pmx_src_t;

  typedef enum logic [2:0] {
    RXSEL_REMOTE0 = 3'b000,
    RXSEL_REMOTE1 = 3'b001,
    RXSEL_REMOTE2 = 3'b010,
    RXSEL_REMOTE3 = 3'b011,
    RXSEL_LOCK = 3'b100,
    RXSEL_PASS = 3'b101,
    RXSEL_FRAME = 3'b110,
    RXSEL_LINE = 3'b111
  } pmx_rxsel_t;

  typedef enum logic [2:0] {
    DEVSEL_LOCAL = 3'b000,
    DEVSEL_LOCK_OR = 3'b001,
    DEVSEL_LOCK_AND = 3'b010,
    DEVSEL_PASS_AND = 3'b011,
    DEVSEL_FSYNC = 3'b100
  } pmx_devsel_t;

  typedef enum logic [2:0] {
    TXSEL_PASS_AND = 3'b000,
    TXSEL_PASS_OR = 3'b001,
    TXSEL_FRAME = 3'b010,
    TXSEL_LINE = 3'b011,
    TXSEL_SYNCED = 3'b100,
    TXSEL_IRQ = 3'b101
  } pmx_txsel_t;

endpackage : pmx_pkg

// *** include/pmx_rx_if.sv ***
// status of one receive port and the select that picks from it
interface pmx_rx_if;
  logic [3:0] remoteLevel;
  logic lock;
  logic pass;
  logic frameValid;
  logic lineValid;
  logic [2:0] sel;
  logic pick;
  modport src (output remoteLevel, output lock, output pass, output frameValid, output lineValid,
    output sel, input pick);
  modport sink (input remoteLevel, input lock, input pass, input frameValid, input lineValid,
    input sel, output pick);
endinterface : pmx_rx_if

// *** verilog/pmx_rx_port_sel.sv ***
// picks one status bit of a receive port by select code
module pmx_rx_port_sel (
  pmx_rx_if.sink port
);
  import pmx_pkg::*;

  wire pmx_rxsel_t selCode = pmx_rxsel_t'(port.sel);
  wire isRemote = (port.sel[2] == 1'b0);
  wire remoteBit = port.remoteLevel[port.sel[1:0]];
  wire lockBit = (selCode == RXSEL_LOCK) & port.lock;
  wire passBit = (selCode == RXSEL_PASS) & port.pass;
  wire frameBit = (selCode == RXSEL_FRAME) & port.frameValid;
  wire lineBit = (selCode == RXSEL_LINE) & port.lineValid;

  assign port.pick = isRemote ? remoteBit : (lockBit | passBit | frameBit | lineBit);

endmodule : pmx_rx_port_sel

// *** testbench/pmx_asserts.sv ***
// concurrent checks on the ports of the pin output source mux
module pmx_asserts (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] rxRemoteLevel,
  input wire logic [3:0] rxLock,
  input wire logic [3:0] rxPass,
  input wire logic [3:0] rxFrameValid,
  input wire logic [3:0] rxLineValid,
  input wire logic txFrameValid,
  input wire logic txLineValid,
  input wire logic txSynced,
  input wire logic txIrq,
  input wire logic frameSyncPulse,
  input wire logic pin2PadOut,
  input wire logic pin2PadOe_b
);
  logic [36:0] statVec;
  assign statVec = {frameSyncPulse, txIrq, txSynced, txLineValid, txFrameValid, rxLineValid, rxFrameValid,
    rxPass, rxLock, rxRemoteLevel};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_reset_pin_off: assert property (disable iff (1'b0) !rst_b |=> pin2PadOe_b && !pin2PadOut)
    else $error("pin not released in reset");
  chk_undriven_low: assert property (pin2PadOe_b |-> !pin2PadOut)
    else $error("pin data high while undriven");
  chk_enable_by_write: assert property ($changed(pin2PadOe_b) |-> $past(s_axi_bvalid))
    else $error("drive enable moved without a write");
  // pin may only move after a write or a status change one edge earlier
  chk_pin_has_cause: assert property ($changed(pin2PadOut) |->
    $past(s_axi_bvalid) || ($past(statVec) != $past(statVec, 2)))
    else $error("pin level moved without cause");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not on time");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not on time");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  chk_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
  cov_enable: cover property ($fell(pin2PadOe_b));
  cov_pin_rise: cover property ($rose(pin2PadOut));
endmodule : pmx_asserts

bind pmx_pin_output_source_mux pmx_asserts pmx_asserts_i (.*);

// *** testbench/pmx_board_sampler.sv ***
// board logic on the far side of pin 2
module pmx_board_sampler (
  input wire logic clk_sys,
  input wire logic padOut,
  input wire logic padOe_b,
  output logic padLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lastDriven_reg = 1'b0;
  always_ff @(posedge clk_sys) begin
    if (!padOe_b) lastDriven_reg <= padOut;
  end
  // no pull on the board, so a floating pad must not look like the old level
  assign padLevel = padOe_b ? ~lastDriven_reg : padOut;
endmodule : pmx_board_sampler

// *** testbench/pmx_pin_output_source_mux_tb.sv ***
// self-checking bench of the pin output source mux
`include "pmx_defines.svh"
module pmx_pin_output_source_mux_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pmx_pkg::*;
  localparam logic [7:0] CTRL_ADDR = 8'(4 * `PMX_CTRL_INDEX);
  localparam logic [7:0] MASK_ADDR = 8'(4 * `PMX_PORTS_INDEX);
  localparam logic [7:0] STAT_ADDR = 8'(4 * `PMX_STATUS_INDEX);
  logic clk_sys = 1'b0, rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, maskVal = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  pmx_resp_t s_axi_bresp, s_axi_rresp;
  logic [15:0] rxRemoteLevel;
  logic [3:0] rxLock, rxPass, rxFrameValid, rxLineValid;
  logic txFrameValid, txLineValid, txSynced, txIrq, frameSyncPulse, pin2PadIn, pin2PadOut, pin2PadOe_b;
  logic [36:0] stim = 37'h159546A53C;
  int numErrors = 0, samplesChecked = 0;
  assign {frameSyncPulse, txIrq, txSynced, txLineValid, txFrameValid, rxLineValid, rxFrameValid, rxPass, rxLock,
    rxRemoteLevel} = stim;
  always #50 clk_sys = ~clk_sys;
  pmx_pin_output_source_mux pmx_pin_output_source_mux_i (.*);
  pmx_board_sampler pmx_board_sampler_i (.clk_sys(clk_sys), .padOut(pin2PadOut), .padOe_b(pin2PadOe_b),
    .padLevel(pin2PadIn));
  task automatic complete_run();
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic timeout_hit();
    numErrors++;
    $display("wait bound used up at %0t", $time);
    complete_run();
  endtask : timeout_hit
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input pmx_resp_t er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (s_axi_bvalid) break;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (n == 20) timeout_hit();
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input pmx_resp_t er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (s_axi_rvalid) break;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (n == 20) timeout_hit();
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_read
  // expected pin level from the control byte and the status now driven
  function automatic logic exp_pin(input logic [7:0] c);
    logic [3:0] en;
    logic [3:0] tm;
    logic [3:0] rxStat;
    en = maskVal[3:0];
    tm = maskVal[7:4];
    rxStat = {rxLineValid[c[3:2]], rxFrameValid[c[3:2]], rxPass[c[3:2]], rxLock[c[3:2]]};
    if (!c[0]) return 1'b0;
    if (!c[4]) return c[7] ? rxStat[c[6:5]] : rxRemoteLevel[{c[3:2], c[6:5]}];
    if (c[4:2] == 3'h4) case (c[7:5])
      3'h0: return c[1];
      3'h1: return |(rxLock & en);
      3'h2: return (en != 4'h0) && ((rxLock & en) == en);
      3'h3: return (en != 4'h0) && ((rxPass & en) == en);
      3'h4: return frameSyncPulse;
      default: return 1'b0;
    endcase
    if (c[4:2] == 3'h6) case (c[7:5])
      3'h0: return (tm != 4'h0) && ((rxPass & tm) == tm);
      3'h1: return |(rxPass & tm);
      3'h2: return txFrameValid;
      3'h3: return txLineValid;
      3'h4: return txSynced;
      3'h5: return txIrq;
      default: return 1'b0;
    endcase
    return 1'b0;
  endfunction : exp_pin
  task automatic pin_check(input logic [7:0] c);
    repeat (2) @(posedge clk_sys);
    chk({30'h0, pin2PadOe_b, pin2PadOut}, {30'h0, ~c[0], exp_pin(c)});
  endtask : pin_check
  // every select code of one group, each under the pattern and its inverse
  task automatic sweep(input logic [2:0] g, input logic lvl, input logic en);
    logic [7:0] c;
    for (int s = 0; s < 8; s++) begin
      c = {3'(s), g, lvl, en};
      axi_write(CTRL_ADDR, {24'h0, c}, `PMX_RESP_OKAY);
      pin_check(c);
      stim <= ~stim;
      pin_check(c);
    end
  endtask : sweep
  task automatic set_mask(input logic [7:0] m);
    maskVal = m;
    axi_write(MASK_ADDR, {24'h0, m}, `PMX_RESP_OKAY);
  endtask : set_mask
  task automatic scen_reset();
    axi_read(CTRL_ADDR, 32'h0, `PMX_RESP_OKAY);
    chk({30'h0, pin2PadOe_b, pin2PadOut}, 32'h2);
    // pad never driven yet, so the floating pad reads high
    axi_read(STAT_ADDR, 32'h0000_0030, `PMX_RESP_OKAY);
  endtask : scen_reset
  task automatic scen_rx_ports();
    for (int p = 0; p < 4; p++) sweep(3'(p), 1'b0, 1'b1);
  endtask : scen_rx_ports
  task automatic scen_device();
    set_mask(8'h06);
    sweep(3'h4, 1'b1, 1'b1);
    set_mask(8'h0C);
    sweep(3'h4, 1'b0, 1'b1);
  endtask : scen_device
  task automatic scen_tx();
    set_mask(8'hC0);
    sweep(3'h6, 1'b0, 1'b1);
    set_mask(8'h40);
    sweep(3'h6, 1'b1, 1'b1);
  endtask : scen_tx
  task automatic scen_reserved_off();
    sweep(3'h5, 1'b1, 1'b1);
    sweep(3'h7, 1'b1, 1'b1);
    sweep(3'h4, 1'b1, 1'b0);
  endtask : scen_reserved_off
  task automatic scen_bus();
    axi_write(8'h40, 32'h0000_00FF, `PMX_RESP_SLVERR);
    axi_read(CTRL_ADDR, 32'h0000_00F2, `PMX_RESP_OKAY);
    // lane 0 strobe low: the write must leave the control byte alone
    s_axi_wstrb <= 4'hE;
    axi_write(CTRL_ADDR, 32'h0000_0000, `PMX_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_read(CTRL_ADDR, 32'h0000_00F2, `PMX_RESP_OKAY);
    axi_read(8'h00, 32'h0, `PMX_RESP_SLVERR);
    axi_write(STAT_ADDR, 32'h0000_00FF, `PMX_RESP_OKAY);
    axi_read(MASK_ADDR, 32'h0000_0040, `PMX_RESP_OKAY);
    // device group, reserved select, driver off; last driven level was low
    axi_read(STAT_ADDR, 32'h0000_0031, `PMX_RESP_OKAY);
  endtask : scen_bus
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    scen_reset();
    scen_rx_ports();
    scen_device();
    scen_tx();
    scen_reserved_off();
    scen_bus();
    complete_run();
  end
endmodule : pmx_pin_output_source_mux_tb
